// *** include/odf_pkg.sv ***
package odf_pkg;

	// Clock rate and gap timer step.
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned GAP_STEP_MS  = 10;
	localparam int unsigned GAP_STEP_CYC = GAP_STEP_MS * 1000 * CLK_MHZ;

	// Register byte offsets.
	localparam logic [5:0] REG_CTRL   = 6'h00;
	localparam logic [5:0] REG_MBOX   = 6'h04;
	localparam logic [5:0] REG_FLAG   = 6'h08;
	localparam logic [5:0] REG_GAP    = 6'h0C;
	localparam logic [5:0] REG_TERM   = 6'h10;
	localparam logic [5:0] REG_TXCNT  = 6'h14;
	localparam logic [5:0] REG_TXDATA = 6'h18;
	localparam logic [5:0] REG_STATUS = 6'h1C;
	localparam logic [5:0] REG_MASK   = 6'h20;
	localparam logic [5:0] REG_RXCNT  = 6'h24;

	// Field positions.
	localparam int CTRL_MODE     = 0;
	localparam int CTRL_CPU_LSB  = 1;
	localparam int CTRL_EXT      = 4;
	localparam int CTRL_BLK_LSB  = 8;
	localparam int MBOX_OFF_LSB  = 0;
	localparam int MBOX_LEN_LSB  = 16;
	localparam int FLAG_EN       = 0;
	localparam int FLAG_BYTE_LSB = 8;
	localparam int FLAG_BIT_LSB  = 16;
	localparam int TERM_ID2_LSB  = 8;

	// Status and mask bit positions.
	localparam int ST_RX_DONE  = 0;
	localparam int ST_RX_ABORT = 1;
	localparam int ST_RX_OVF   = 2;
	localparam int ST_RX_BLOCK = 3;
	localparam int ST_TX_DONE  = 4;

	// Ranges and reset values.
	localparam logic [15:0] CPU_MAX   = 16'h0004;
	localparam logic [15:0] BLK_MIN   = 16'h0003;
	localparam logic [15:0] BLK_MAX   = 16'h00FF;
	localparam logic [15:0] LEN_MIN   = 16'h0002;
	localparam logic [15:0] LEN_MAX   = 16'h0801;
	localparam logic [15:0] FBYTE_MAX = 16'h00DF;
	localparam logic [15:0] GAP_MIN   = 16'h0001;
	localparam logic [15:0] GAP_MAX   = 16'hF82F;
	localparam logic [7:0]  RST_BLK   = 8'h03;
	localparam logic [11:0] RST_LEN   = 12'h002;
	localparam logic [15:0] RST_GAP   = 16'h0001;

	// Clamps a field value into its legal range.
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Detects the terminator: single byte id2 when id1 is zero, else id1 then id2.
	function automatic logic term_hit(input logic [7:0] prev, input logic [7:0] b,
		input logic has_prev, input logic [7:0] id1, input logic [7:0] id2);
		term_hit = (id1 == 8'h00) ? (b == id2) : (has_prev && prev == id1 && b == id2);
	endfunction

endpackage

// *** core/odf_rx_ram.sv ***
`timescale 1ns/1ps
module odf_rx_ram (
	input  wire logic        clk_sys,
	input  wire logic        we,
	input  wire logic [10:0] waddr,
	input  wire logic [15:0] wdata,
	input  wire logic [10:0] raddr,
	output logic      [15:0] rdata
);

	logic [15:0] mem [0:2047];
	logic [15:0] rdata_q;

	// Message words are held here until they are copied to the mailbox.
	always_ff @(posedge clk_sys)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[raddr];
	end

	assign rdata = rdata_q;

endmodule // odf_rx_ram

// *** core/odf_gap_timer.sv ***
`timescale 1ns/1ps
module odf_gap_timer #(
	parameter int unsigned STEP_CYC = odf_pkg::GAP_STEP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        restart,
	input  wire logic        run,
	input  wire logic [15:0] timeout,
	output logic             expired
);

	localparam int PW = $clog2(STEP_CYC + 1);

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [15:0]   ticks;
		logic          exp;
	} odf_gap_t;

	odf_gap_t q;
	odf_gap_t d;

	// Counts 10 ms steps from the last character until the timeout is reached.
	always_comb
	begin
		d = q;
		d.exp = 1'b0;
		if (restart || !run)
		begin
			d.pre = '0;
			d.ticks = '0;
		end
		else if (q.pre == PW'(STEP_CYC - 1))
		begin
			d.pre = '0;
			d.ticks = q.ticks + 16'h0001;
			d.exp = (q.ticks + 16'h0001) >= timeout;
		end
		else
		begin
			d.pre = q.pre + PW'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign expired = q.exp;

endmodule // odf_gap_timer

// *** core/odf_framer.sv ***
`timescale 1ns/1ps
module odf_framer #(
	parameter int unsigned GAP_STEP_CYC = odf_pkg::GAP_STEP_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic             mbx_we,
	output logic      [2:0]  mbx_cpu,
	output logic             mbx_ext,
	output logic      [7:0]  mbx_block,
	output logic      [12:0] mbx_addr,
	output logic      [15:0] mbx_data,
	input  wire logic        coord_busy,
	output logic             coord_set,
	output logic      [7:0]  coord_byte,
	output logic      [2:0]  coord_bit
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_RECV,
		S_WCNT,
		S_RD,
		S_WR,
		S_DONE
	} odf_fsm_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        mode;
		logic [2:0]  cpu;
		logic        ext;
		logic [7:0]  blk;
		logic [10:0] start;
		logic [11:0] len;
		logic        fl_en;
		logic [7:0]  fl_byte;
		logic [2:0]  fl_bit;
		logic [15:0] gap;
		logic [7:0]  id1;
		logic [7:0]  id2;
		logic [4:0]  st;
		logic [4:0]  mask;
		logic        irq;
		logic [11:0] tx_left;
		logic [7:0]  tx_data;
		logic [7:0]  tx_prev;
		logic        tx_any;
		logic        tx_valid;
		logic        tx_last;
		logic [12:0] rx_cnt;
		logic [12:0] last_cnt;
		logic [7:0]  rx_prev;
		logic        ovf;
		odf_fsm_t    fsm;
		logic [11:0] idx;
		logic        mb_we;
		logic [12:0] mb_addr;
		logic [15:0] mb_data;
		logic        cf_set;
		logic        sync1;
		logic        sync2;
	} odf_state_t;

	odf_state_t  q;
	odf_state_t  d;
	logic [1:0]  rst_s;
	logic        rst_n;
	logic        ram_we;
	logic [10:0] ram_waddr;
	logic [15:0] ram_wdata;
	logic [15:0] ram_rdata;
	logic        gap_restart;
	logic        gap_run;
	logic        gap_exp;
	logic        req;
	logic        wr_acc;
	logic        rd_acc;
	logic [4:0]  st_set;
	logic [4:0]  st_clr;
	logic [12:0] max_bytes;
	logic [12:0] cnt_p1;
	logic        rx_take;
	logic        rx_end;
	logic        hit;

	// Reset is released through two flip-flops.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s <= 2'h0;
		end
		else
		begin
			rst_s <= {rst_s[0], 1'b1};
		end
	end

	assign rst_n = rst_s[1];

	odf_rx_ram odf_rx_ram_i (
		.clk_sys (clk_sys),
		.we      (ram_we),
		.waddr   (ram_waddr),
		.wdata   (ram_wdata),
		.raddr   (q.idx[10:0]),
		.rdata   (ram_rdata)
	);

	odf_gap_timer #(
		.STEP_CYC (GAP_STEP_CYC)
	) odf_gap_timer_i (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.restart (gap_restart),
		.run     (gap_run),
		.timeout (q.gap),
		.expired (gap_exp)
	);

	always_comb
	begin
		d = q;
		d.mb_we = 1'b0;
		d.cf_set = 1'b0;
		d.sync1 = coord_busy;
		d.sync2 = q.sync1;
		st_set = 5'h00;
		st_clr = 5'h00;
		ram_we = 1'b0;
		ram_waddr = q.rx_cnt[11:1];
		ram_wdata = 16'h0000;
		gap_restart = 1'b0;
		gap_run = 1'b0;
		rx_end = 1'b0;
		hit = 1'b0;
		max_bytes = {q.len - 12'h001, 1'b0};
		cnt_p1 = q.last_cnt + 13'h0001;
		req = avs_read || avs_write;
		wr_acc = 1'b0;
		rd_acc = 1'b0;

		// Bus slave: one access accepted, waitrequest low on the next cycle.
		d.ack = 1'b0;
		if (req && !q.ack)
		begin
			if (!(avs_write && avs_address == odf_pkg::REG_TXDATA && q.tx_valid))
			begin
				d.ack = 1'b1;
				wr_acc = avs_write;
				rd_acc = avs_read;
			end
		end
		if (rd_acc)
		begin
			case (avs_address)
				odf_pkg::REG_CTRL:   d.rdata = {16'h0000, q.blk, 3'h0, q.ext, q.cpu, q.mode};
				odf_pkg::REG_MBOX:   d.rdata = {4'h0, q.len, 5'h00, q.start};
				odf_pkg::REG_FLAG:   d.rdata = {13'h0000, q.fl_bit, q.fl_byte, 7'h00, q.fl_en};
				odf_pkg::REG_GAP:    d.rdata = {16'h0000, q.gap};
				odf_pkg::REG_TERM:   d.rdata = {16'h0000, q.id2, q.id1};
				odf_pkg::REG_TXCNT:  d.rdata = {20'h00000, q.tx_left};
				odf_pkg::REG_STATUS: d.rdata = {27'h0000000, q.st};
				odf_pkg::REG_MASK:   d.rdata = {27'h0000000, q.mask};
				odf_pkg::REG_RXCNT:  d.rdata = {19'h00000, q.last_cnt};
				default:             d.rdata = 32'h00000000;
			endcase
			if (avs_address == odf_pkg::REG_STATUS)
			begin
				st_clr = 5'h1F;
			end
		end
		if (wr_acc)
		begin
			case (avs_address)
				odf_pkg::REG_CTRL:
				begin
					d.mode = avs_writedata[odf_pkg::CTRL_MODE];
					d.cpu = 3'(odf_pkg::clamp(16'(avs_writedata[odf_pkg::CTRL_CPU_LSB +: 3]),
						16'h0000, odf_pkg::CPU_MAX));
					d.ext = avs_writedata[odf_pkg::CTRL_EXT];
					d.blk = 8'(odf_pkg::clamp(16'(avs_writedata[odf_pkg::CTRL_BLK_LSB +: 8]),
						odf_pkg::BLK_MIN, odf_pkg::BLK_MAX));
				end
				odf_pkg::REG_MBOX:
				begin
					d.start = avs_writedata[odf_pkg::MBOX_OFF_LSB +: 11];
					d.len = 12'(odf_pkg::clamp(16'(avs_writedata[odf_pkg::MBOX_LEN_LSB +: 12]),
						odf_pkg::LEN_MIN, odf_pkg::LEN_MAX));
				end
				odf_pkg::REG_FLAG:
				begin
					d.fl_en = avs_writedata[odf_pkg::FLAG_EN];
					d.fl_byte = 8'(odf_pkg::clamp(16'(avs_writedata[odf_pkg::FLAG_BYTE_LSB +: 8]),
						16'h0000, odf_pkg::FBYTE_MAX));
					d.fl_bit = avs_writedata[odf_pkg::FLAG_BIT_LSB +: 3];
				end
				odf_pkg::REG_GAP:
					d.gap = odf_pkg::clamp(avs_writedata[15:0], odf_pkg::GAP_MIN,
						odf_pkg::GAP_MAX);
				odf_pkg::REG_TERM:
				begin
					d.id1 = avs_writedata[7:0];
					d.id2 = avs_writedata[odf_pkg::TERM_ID2_LSB +: 8];
				end
				odf_pkg::REG_TXCNT:
				begin
					// Byte count n starts a send.
					d.tx_left = avs_writedata[11:0];
					d.tx_any = 1'b0;
				end
				odf_pkg::REG_TXDATA:
				begin
					if (q.tx_left != 12'h000)
					begin
						hit = q.mode && odf_pkg::term_hit(q.tx_prev, avs_writedata[7:0],
							q.tx_any, q.id1, q.id2);
						d.tx_data = avs_writedata[7:0];
						d.tx_prev = avs_writedata[7:0];
						d.tx_any = 1'b1;
						d.tx_valid = 1'b1;
						d.tx_last = hit || q.tx_left == 12'h001;
						d.tx_left = hit ? 12'h000 : q.tx_left - 12'h001;
					end
				end
				odf_pkg::REG_MASK:   d.mask = avs_writedata[4:0];
				default:             d.mask = q.mask;
			endcase
		end
		if (q.tx_valid && tx_ready)
		begin
			d.tx_valid = 1'b0;
			st_set[odf_pkg::ST_TX_DONE] = q.tx_last;
		end

		// Receive path.
		rx_take = rx_valid && (q.fsm == S_IDLE || q.fsm == S_RECV);
		if (rx_take)
		begin
			gap_restart = 1'b1;
			d.fsm = S_RECV;
			d.rx_prev = rx_data;
			if (q.rx_cnt >= max_bytes)
			begin
				d.ovf = 1'b1;
			end
			else
			begin
				// Even byte zero-fills the low half.
				ram_we = 1'b1;
				ram_wdata = q.rx_cnt[0] ? {q.rx_prev, rx_data} : {rx_data, 8'h00};
				d.rx_cnt = q.rx_cnt + 13'h0001;
			end
			rx_end = q.mode && odf_pkg::term_hit(q.rx_prev, rx_data, q.fsm == S_RECV,
				q.id1, q.id2);
		end
		// Timer runs only within a message.
		gap_run = q.fsm == S_RECV;

		case (q.fsm)
			S_IDLE:
			begin
				d.rx_cnt = rx_take ? d.rx_cnt : 13'h0000;
			end
			S_RECV:
			begin
				if (gap_exp && !rx_take && q.mode)
				begin
					st_set[odf_pkg::ST_RX_ABORT] = 1'b1;
					d.fsm = S_IDLE;
					d.ovf = 1'b0;
					d.rx_cnt = 13'h0000;
				end
				else if (gap_exp && !rx_take)
				begin
					rx_end = 1'b1;
				end
			end
			S_WCNT:
			begin
				d.mb_we = 1'b1;
				d.mb_addr = 13'(q.start);
				d.mb_data = 16'(q.last_cnt);
				d.idx = 12'h000;
				d.fsm = S_RD;
			end
			S_RD:
			begin
				d.fsm = S_WR;
			end
			S_WR:
			begin
				// Words past the payload are zero.
				d.mb_we = 1'b1;
				d.mb_addr = 13'(q.start) + 13'(q.idx) + 13'h0001;
				d.mb_data = ({1'b0, q.idx} < {1'b0, cnt_p1[12:1]}) ? ram_rdata : 16'h0000;
				d.idx = q.idx + 12'h001;
				d.fsm = (q.idx == q.len - 12'h002) ? S_DONE : S_RD;
			end
			S_DONE:
			begin
				d.cf_set = q.fl_en;
				st_set[odf_pkg::ST_RX_DONE] = 1'b1;
				d.fsm = S_IDLE;
			end
			default:
			begin
				d.fsm = S_IDLE;
			end
		endcase

		if (rx_end)
		begin
			d.fsm = S_IDLE;
			if (d.ovf || q.ovf)
			begin
				st_set[odf_pkg::ST_RX_OVF] = 1'b1;
			end
			else if (q.fl_en && q.sync2)
			begin
				st_set[odf_pkg::ST_RX_BLOCK] = 1'b1;
			end
			else
			begin
				d.last_cnt = d.rx_cnt;
				d.fsm = S_WCNT;
			end
			// The next message counts from zero with no overflow pending.
			d.ovf = 1'b0;
			d.rx_cnt = 13'h0000;
		end

		// Set wins over a read clear.
		d.st = (q.st & ~st_clr) | st_set;
		d.irq = |(d.st & d.mask);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.cpu <= 3'h1;
			q.blk <= odf_pkg::RST_BLK;
			q.len <= odf_pkg::RST_LEN;
			q.gap <= odf_pkg::RST_GAP;
			q.fsm <= S_IDLE;
		end
		else
		begin
			q <= d;
		end
	end

	assign avs_readdata = q.rdata;
	assign avs_waitrequest = !q.ack;
	assign irq = q.irq;
	assign tx_data = q.tx_data;
	assign tx_valid = q.tx_valid;
	assign mbx_we = q.mb_we;
	// Writes go to the selected processor only.
	assign mbx_cpu = q.cpu;
	assign mbx_ext = q.ext;
	assign mbx_block = q.blk;
	assign mbx_addr = q.mb_addr;
	assign mbx_data = q.mb_data;
	assign coord_set = q.cf_set;
	assign coord_byte = q.fl_byte;
	assign coord_bit = q.fl_bit;

endmodule // odf_framer

// *** testbench/odf_framer_asserts.sv ***
`timescale 1ns/1ps
module odf_framer_asserts (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic [5:0] avs_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [7:0] tx_data,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       mbx_we,
	input wire logic [2:0] mbx_cpu,
	input wire logic [7:0] mbx_block,
	input wire logic       coord_set,
	input wire logic [7:0] coord_byte
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read not answered in one cycle");
	a_write_answer: assert property (avs_write && avs_waitrequest
		&& avs_address != odf_pkg::REG_TXDATA |=> !avs_waitrequest)
		else $error("write not answered in one cycle");
	a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_cpu_range: assert property (mbx_we |-> mbx_cpu <= 3'h4)
		else $error("target processor out of range");
	a_block_range: assert property (mbx_we |-> mbx_block >= 8'h03)
		else $error("block number below range");
	a_flag_range: assert property (coord_set |-> coord_byte <= 8'hDF)
		else $error("flag byte out of range");
	a_flag_pulse: assert property (coord_set |=> !coord_set)
		else $error("flag set longer than one cycle");
	a_word_spacing: assert property (mbx_we |=> !mbx_we ##1 1'b1)
		else $error("mailbox writes too close");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte changed before accepted");
	a_tx_release: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("tx byte not released after accept");
	c_word: cover property (mbx_we);
	c_flag: cover property (coord_set);
	c_tx: cover property (tx_valid && tx_ready);
	c_stall: cover property (avs_write && avs_waitrequest && tx_valid);
endmodule // odf_framer_asserts

// *** testbench/odf_partner.sv ***
`timescale 1ns/1ps
module odf_partner (
	input  wire logic       clk_sys,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got [$];
	int         slow = 0;
	int         waited = 0;
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// Sends one character, then shows its inverse on the idle line.
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		rx_data <= b;
		rx_valid <= 1'b1;
		@(posedge clk_sys);
		rx_data <= ~b;
		rx_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// Accepts each transmitted byte after a stall of slow plus one cycles.
	always @(posedge clk_sys)
	begin
		if (tx_valid && tx_ready)
		begin
			got.push_back(tx_data);
			tx_ready <= 1'b0;
			waited <= 0;
		end
		else if (tx_valid)
		begin
			tx_ready <= (waited >= slow);
			waited <= waited + 1;
		end
	end
endmodule // odf_partner

// *** testbench/odf_framer_tb.sv ***
`timescale 1ns/1ps
module odf_framer_tb;
	logic        clk_sys = 1'b0;
	logic        rstn;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	logic        mbx_we;
	logic [2:0]  mbx_cpu;
	logic        mbx_ext;
	logic [7:0]  mbx_block;
	logic [12:0] mbx_addr;
	logic [15:0] mbx_data;
	logic        coord_busy;
	logic        coord_set;
	logic [7:0]  coord_byte;
	logic [2:0]  coord_bit;
	logic [15:0] mem [0:63];
	int          errors = 0;
	int          checked = 0;
	int          nwr = 0;
	int          ncs = 0;

	always #2.5 clk_sys = ~clk_sys;

	odf_framer #(.GAP_STEP_CYC(10)) odf_framer_i (.clk_sys(clk_sys), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .rx_data(rx_data),
		.rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.mbx_we(mbx_we), .mbx_cpu(mbx_cpu), .mbx_ext(mbx_ext), .mbx_block(mbx_block),
		.mbx_addr(mbx_addr), .mbx_data(mbx_data), .coord_busy(coord_busy),
		.coord_set(coord_set), .coord_byte(coord_byte), .coord_bit(coord_bit));
	odf_partner odf_partner_i (.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	task automatic results;
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Mailbox words land in a local image.
	always @(posedge clk_sys)
	begin
		if (mbx_we === 1'b1)
		begin
			mem[mbx_addr[5:0]] = mbx_data;
			nwr++;
			chk({20'h0, mbx_ext, mbx_cpu, mbx_block}, 32'h403);
		end
		if (coord_set === 1'b1)
			ncs++;
	end
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do
		begin
			@(posedge clk_sys);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wirq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 500)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
	endtask
	task automatic rxs(input logic [7:0] b [$]);
		foreach (b[i]) odf_partner_i.send(b[i]);
	endtask
	task automatic mbc(input int a, input logic [15:0] w [$]);
		foreach (w[i]) chk({16'h0, mem[a + i]}, {16'h0, w[i]});
	endtask
	task automatic t_regs;
		rdc(odf_pkg::REG_CTRL, 32'h0302);
		rdc(odf_pkg::REG_MBOX, 32'h0002_0000);
		rdc(6'h3C, 32'h0);
		wr(odf_pkg::REG_GAP, 32'hFFFF);
		rdc(odf_pkg::REG_GAP, 32'hF82F);
		wr(odf_pkg::REG_GAP, 32'h0);
		rdc(odf_pkg::REG_GAP, 32'h1);
		wr(odf_pkg::REG_CTRL, 32'h0010);
		rdc(odf_pkg::REG_CTRL, 32'h0310);
		wr(odf_pkg::REG_CTRL, 32'h010E);
		rdc(odf_pkg::REG_CTRL, 32'h0308);
		wr(odf_pkg::REG_MBOX, 32'h0FFF_0005);
		rdc(odf_pkg::REG_MBOX, 32'h0801_0005);
		wr(odf_pkg::REG_FLAG, 32'h0007_FF01);
		rdc(odf_pkg::REG_FLAG, 32'h0007_DF01);
		wr(odf_pkg::REG_MASK, 32'h1F);
	endtask
	task automatic t_fixed;
		wr(odf_pkg::REG_MBOX, 32'h0006_0005);
		rxs('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		mbc(5, '{16'h7, 16'h0102, 16'h0304, 16'h0506, 16'h0700, 16'h0});
		chk(nwr, 6);
		chk(ncs, 1);
		chk({21'h0, coord_bit, coord_byte}, 32'h7DF);
		rdc(odf_pkg::REG_RXCNT, 32'h7);
	endtask
	task automatic t_end;
		wr(odf_pkg::REG_CTRL, 32'h0309);
		wr(odf_pkg::REG_TERM, 32'h0A0D);
		wr(odf_pkg::REG_GAP, 32'h3);
		wr(odf_pkg::REG_MBOX, 32'h0006_0014);
		rxs('{8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h1);
		mbc(20, '{16'h5, 16'h410D, 16'h420D, 16'h0A00, 16'h0, 16'h0});
		wr(odf_pkg::REG_TERM, 32'h0A00);
		rxs('{8'h0D, 8'h0A});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h1);
		mbc(20, '{16'h2, 16'h0D0A, 16'h0, 16'h0, 16'h0, 16'h0});
	endtask
	task automatic t_abort;
		wr(odf_pkg::REG_MASK, 32'h1);
		nwr = 0;
		rxs('{8'h41, 8'h42});
		repeat (60) @(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		chk(nwr, 0);
		rdc(odf_pkg::REG_STATUS, 32'h2);
		wr(odf_pkg::REG_MASK, 32'h1F);
	endtask
	task automatic t_block;
		wr(odf_pkg::REG_CTRL, 32'h0308);
		wr(odf_pkg::REG_GAP, 32'h1);
		coord_busy <= 1'b1;
		rxs('{8'h41});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h8);
		chk(nwr, 0);
		coord_busy <= 1'b0;
	endtask
	task automatic t_ovf;
		wr(odf_pkg::REG_MBOX, 32'h0002_001E);
		rxs('{8'h41, 8'h42, 8'h43});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h4);
		chk(nwr, 0);
		rxs('{8'h41, 8'h42});
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h1);
		mbc(30, '{16'h2, 16'h4142});
	endtask
	task automatic t_tx;
		logic [7:0] e [$];
		e = '{8'h41, 8'h42, 8'h43, 8'h41, 8'h0A};
		odf_partner_i.slow = 3;
		wr(odf_pkg::REG_TXCNT, 32'h3);
		foreach (e[i]) if (i < 3) wr(odf_pkg::REG_TXDATA, {24'h0, e[i]});
		wr(odf_pkg::REG_TXDATA, 32'h44);
		wirq;
		rdc(odf_pkg::REG_STATUS, 32'h10);
		wr(odf_pkg::REG_CTRL, 32'h0309);
		odf_partner_i.slow = 0;
		wr(odf_pkg::REG_TXCNT, 32'h4);
		wr(odf_pkg::REG_TXDATA, 32'h41);
		wr(odf_pkg::REG_TXDATA, 32'h0A);
		wirq;
		wr(odf_pkg::REG_TXDATA, 32'h42);
		rdc(odf_pkg::REG_STATUS, 32'h10);
		repeat (10) @(posedge clk_sys);
		chk(odf_partner_i.got.size(), e.size());
		foreach (e[i]) chk({24'h0, odf_partner_i.got[i]}, {24'h0, e[i]});
	endtask
	initial
	begin
		rstn = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		coord_busy = 1'b0;
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_regs;
		t_fixed;
		t_end;
		t_abort;
		t_block;
		t_ovf;
		t_tx;
		results;
	end
	initial
	begin
		#100000;
		errors++;
		results;
	end
endmodule // odf_framer_tb
bind odf_framer odf_framer_asserts odf_framer_asserts_i (.clk_sys(clk_sys), .rstn(rstn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .tx_data(tx_data), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .mbx_we(mbx_we), .mbx_cpu(mbx_cpu), .mbx_block(mbx_block),
	.coord_set(coord_set), .coord_byte(coord_byte));
